// *** rtl/gtp_map.vh ***
// register offsets, field positions, reset values and counts for the gated timer pair
// assumes an 8-bit register port with a 4-bit address
`ifndef GTP_MAP_VH
`define GTP_MAP_VH
`define GTP_OFS_C8_VALUE 4'h0
`define GTP_OFS_C8_CTRL 4'h1
`define GTP_OFS_C16_LOW 4'h2
`define GTP_OFS_C16_HIGH 4'h3
`define GTP_OFS_C16_CTRL 4'h4
`define GTP_OFS_GATE_CTRL 4'h5
`define GTP_OFS_STATUS 4'h6
`define GTP_OFS_OSC_STATE 4'h7
`define GTP_C8_SRC_BIT 0
`define GTP_C8_EDGE_BIT 1
`define GTP_C8_NOPS_BIT 2
`define GTP_C8_RATE_LSB 3
`define GTP_C16_ON_BIT 0
`define GTP_C16_EXT_BIT 1
`define GTP_C16_NOSYNC_BIT 2
`define GTP_C16_OSCEN_BIT 3
`define GTP_C16_PS_LSB 4
`define GTP_GATE_SEL_LSB 0
`define GTP_GATE_VAL_BIT 2
`define GTP_GATE_POL_BIT 6
`define GTP_GATE_EN_BIT 7
`define GTP_ST_C8_FLAG_BIT 0
`define GTP_ST_C16_FLAG_BIT 1
`define GTP_ST_C8_IEN_BIT 4
`define GTP_ST_C16_IEN_BIT 5
`define GTP_OSC_READY_BIT 0
`define GTP_GATE_SRC_PIN 2'h0
`define GTP_GATE_SRC_WRAP 2'h1
`define GTP_GATE_SRC_CMPA 2'h2
`define GTP_GATE_SRC_CMPB 2'h3
`define GTP_C8_CTRL_RST 6'h00
`define GTP_C16_CTRL_RST 6'h00
`define GTP_C8_PS_BASE 8'hFE
`define GTP_C16_PS_BASE 8'hFF
`define GTP_OSC_READY_COUNT 11'h400
`endif

// *** rtl/gtp_top.v ***
// 8-bit timer/counter and 16-bit gated timer/counter with secondary oscillator watch
// assumes one clock enable pulse per instruction cycle; pins are asynchronous to I_CLOCK
//
// What this block does
// (R1) timer mode: count8 advances each instruction cycle
// (R2) count8 write holds counting two cycles
// (R3) source select one: count8 counts external pin
// (R4) edge select picks rising or falling edges
// (R5) count8 has its own 8-bit prescaler, divide by 2 to 256
// (R6) count8 wrap FFh to 00h is gate source
// (R7) count8 wrap sets readable clearable interrupt flag
// (R8) count16 clock divided by 1, 2, 4, 8
// (R9) count16 prescaler hidden, cleared on byte write
// (R10) count16 read as high and low bytes
// (R11) oscillator enable starts oscillator, runs in sleep
// (R12) enable clears ready; set after 1024 cycles
// (R13) sync disable counts external clock unsynchronized
// (R14) async external count runs in sleep, wakes
// (R15) async byte reads always return valid values
// (R16) software stops count16 before writing bytes
// (R17) mode switch may skip or add increment
// (R18) gate disabled counts freely, enabled gates
// (R19) gated counting only when gate equals polarity
// (R20) gate sources: pin, wrap, comparator A
// (R21) gate source 11 picks comparator B
// (R22) each count8 wrap pulses the gate
// (R23) count16 wrap sets readable clearable flag
//
// Chosen here: strobed register access and the placing of the registers.
`include "gtp_map.vh"

module gtp_top (
	input wire I_CLOCK,
	input wire I_RST,
	input wire I_CE,
	input wire [3:0] I_ADDR,
	input wire [7:0] I_WDATA,
	input wire I_WR,
	input wire I_RD,
	output reg [7:0] O_RDATA,
	input wire I_SLEEP,
	input wire I_COUNT8_EXT_CLOCK_PIN,
	input wire I_COUNT16_GATE_PIN,
	input wire I_COMPARATOR_A_SYNC_OUT,
	input wire I_COMPARATOR_B_SYNC_OUT,
	input wire I_SEC_OSC_INPUT_PIN,
	output reg O_SEC_OSC_OUTPUT_PIN,
	output wire O_COUNT8_WRAP_EVENT,
	output wire O_COUNT8_IRQ,
	output wire O_COUNT16_WAKE_IRQ,
	output wire O_SEC_OSC_READY_FLAG
);

	function [7:0] ps_mask;
		input [7:0] base;
		input [2:0] sh;
		begin
			ps_mask = ~(base << sh);
		end
	endfunction

	function wr_at;
		input [3:0] ofs;
		begin
			wr_at = I_WR && (I_ADDR == ofs);
		end
	endfunction

	// pin synchronisers: index 0 count8 pin, 1 gate pin, 2 comparator B, 3 oscillator
	wire [3:0] pin_raw;
	reg [3:0] sync1_q;
	reg [3:0] sync2_q;
	assign pin_raw = {I_SEC_OSC_INPUT_PIN, I_COMPARATOR_B_SYNC_OUT,
		I_COUNT16_GATE_PIN, I_COUNT8_EXT_CLOCK_PIN};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
			always @(posedge I_CLOCK or posedge I_RST) begin
				if (I_RST) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end else if (I_CE) begin
					sync1_q[gi] <= pin_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	// history stages for edge detection, all behind the second sync flop
	reg c8_pin_q;
	reg osc_fast_q;
	reg osc_slow_q;

	always @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			c8_pin_q <= 1'b0;
			osc_fast_q <= 1'b0;
			osc_slow_q <= 1'b0;
		end else if (I_CE) begin
			c8_pin_q <= sync2_q[0];
			osc_fast_q <= sync2_q[3];
			osc_slow_q <= osc_fast_q;
		end
	end

	wire c8_pin_rise;
	wire c8_pin_fall;
	wire osc_rise_fast;
	wire osc_rise_slow;
	assign c8_pin_rise = sync2_q[0] & ~c8_pin_q;
	assign c8_pin_fall = ~sync2_q[0] & c8_pin_q;
	assign osc_rise_fast = sync2_q[3] & ~osc_fast_q;
	// extra phase-alignment stage in synchronous mode; leaving or entering it
	// moves the edge by a cycle, so one increment may be lost or doubled
	assign osc_rise_slow = osc_fast_q & ~osc_slow_q; // [R17]

	// count8 state
	reg [7:0] c8_value_q;
	reg [7:0] c8_value_d;
	reg [5:0] c8_ctrl_q;
	reg [7:0] c8_ps_q;
	reg [7:0] c8_ps_d;
	reg [1:0] c8_hold_q;
	reg [1:0] c8_hold_d;
	reg c8_wrap_q;
	reg c8_wrap_d;

	wire c8_src;
	wire c8_edge;
	wire c8_nops;
	wire [2:0] c8_rate;
	wire [7:0] c8_mask;
	reg c8_evt;
	reg c8_tick;

	assign c8_src = c8_ctrl_q[`GTP_C8_SRC_BIT];
	assign c8_edge = c8_ctrl_q[`GTP_C8_EDGE_BIT];
	assign c8_nops = c8_ctrl_q[`GTP_C8_NOPS_BIT];
	assign c8_rate = c8_ctrl_q[`GTP_C8_RATE_LSB+2:`GTP_C8_RATE_LSB];
	assign c8_mask = ps_mask(`GTP_C8_PS_BASE, c8_rate);

	always @* begin
		c8_evt = 1'b1; // [R1]
		if (c8_src) begin
			c8_evt = c8_edge ? c8_pin_fall : c8_pin_rise; // [R3] [R4]
		end
		c8_ps_d = c8_ps_q;
		c8_tick = 1'b0;
		c8_hold_d = c8_hold_q;
		// instruction clock stops in sleep, so count8 freezes there
		if (c8_hold_q != 2'h0) begin
			c8_hold_d = c8_hold_q - 2'h1; // [R2]
		end else if (c8_evt && !I_SLEEP) begin
			if (c8_nops) begin
				c8_tick = 1'b1; // [R1]
			end else begin
				c8_ps_d = c8_ps_q + 8'h01; // [R5]
				c8_tick = ((c8_ps_q & c8_mask) == c8_mask);
			end
		end
		c8_value_d = c8_value_q;
		if (c8_tick) begin
			c8_value_d = c8_value_q + 8'h01;
		end
		c8_wrap_d = c8_tick && (c8_value_q == 8'hFF); // [R6]
		if (wr_at(`GTP_OFS_C8_VALUE)) begin
			c8_value_d = I_WDATA;
			c8_hold_d = 2'h2; // [R2]
			c8_ps_d = 8'h00;
			// an overwritten count never reaches 00h, so no wrap
			c8_wrap_d = 1'b0; // [R6]
		end
	end

	always @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			c8_value_q <= 8'h00;
			c8_ctrl_q <= `GTP_C8_CTRL_RST;
			c8_ps_q <= 8'h00;
			c8_hold_q <= 2'h0;
			c8_wrap_q <= 1'b0;
		end else if (I_CE) begin
			c8_value_q <= c8_value_d;
			c8_ps_q <= c8_ps_d;
			c8_hold_q <= c8_hold_d;
			c8_wrap_q <= c8_wrap_d;
			if (wr_at(`GTP_OFS_C8_CTRL)) begin
				c8_ctrl_q <= I_WDATA[5:0];
			end
		end
	end

	// one-cycle high pulse per wrap, fed to the gate mux below
	assign O_COUNT8_WRAP_EVENT = c8_wrap_q; // [R22]

	// count16 state
	reg [15:0] c16_value_q;
	reg [15:0] c16_value_d;
	reg [5:0] c16_ctrl_q;
	reg [2:0] c16_ps_q;
	reg [2:0] c16_ps_d;
	reg gate_en_q;
	reg gate_pol_q;
	reg [1:0] gate_sel_q;
	reg gate_lvl;

	wire c16_on;
	wire c16_ext;
	wire c16_nosync;
	wire osc_en;
	wire [7:0] c16_mask;
	wire gate_ok;
	reg c16_evt;
	reg c16_run;
	reg c16_tick;

	assign c16_on = c16_ctrl_q[`GTP_C16_ON_BIT];
	assign c16_ext = c16_ctrl_q[`GTP_C16_EXT_BIT];
	assign c16_nosync = c16_ctrl_q[`GTP_C16_NOSYNC_BIT];
	assign osc_en = c16_ctrl_q[`GTP_C16_OSCEN_BIT];
	assign c16_mask = ps_mask(`GTP_C16_PS_BASE,
		{1'b0, c16_ctrl_q[`GTP_C16_PS_LSB+1:`GTP_C16_PS_LSB]}); // [R8]

	always @* begin
		case (gate_sel_q)
			`GTP_GATE_SRC_PIN: gate_lvl = sync2_q[1]; // [R20]
			`GTP_GATE_SRC_WRAP: gate_lvl = c8_wrap_q; // [R6] [R20] [R22]
			`GTP_GATE_SRC_CMPA: gate_lvl = I_COMPARATOR_A_SYNC_OUT; // [R20]
			`GTP_GATE_SRC_CMPB: gate_lvl = sync2_q[2]; // [R21]
			default: gate_lvl = 1'b0;
		endcase
	end

	// free counting with gate off; otherwise count only at matching level
	assign gate_ok = !gate_en_q || (gate_lvl == gate_pol_q); // [R18] [R19]

	always @* begin
		c16_evt = 1'b1;
		if (c16_ext) begin
			c16_evt = c16_nosync ? osc_rise_fast : osc_rise_slow; // [R13]
		end
		// only the unsynchronised external path survives sleep
		c16_run = c16_on && (!I_SLEEP || (c16_ext && c16_nosync)); // [R14]
		c16_ps_d = c16_ps_q;
		c16_tick = 1'b0;
		if (c16_run && c16_evt) begin
			c16_ps_d = c16_ps_q + 3'h1; // [R8]
			c16_tick = gate_ok && ((c16_ps_q & c16_mask[2:0]) == c16_mask[2:0]); // [R19]
		end
		c16_value_d = c16_value_q;
		if (c16_tick) begin
			c16_value_d = c16_value_q + 16'h0001;
		end
		// a byte write replaces only its own byte of a same-cycle increment; software should stop first
		if (wr_at(`GTP_OFS_C16_LOW)) begin
			c16_value_d[7:0] = I_WDATA; // [R10] [R16]
			c16_ps_d = 3'h0; // [R9]
		end
		if (wr_at(`GTP_OFS_C16_HIGH)) begin
			c16_value_d[15:8] = I_WDATA; // [R10] [R16]
			c16_ps_d = 3'h0; // [R9]
		end
	end

	always @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			c16_value_q <= 16'h0000;
			c16_ctrl_q <= `GTP_C16_CTRL_RST;
			c16_ps_q <= 3'h0;
			gate_en_q <= 1'b0;
			gate_pol_q <= 1'b0;
			gate_sel_q <= 2'h0;
		end else if (I_CE) begin
			c16_value_q <= c16_value_d;
			c16_ps_q <= c16_ps_d;
			if (wr_at(`GTP_OFS_C16_CTRL)) begin
				c16_ctrl_q <= I_WDATA[5:0];
			end
			if (wr_at(`GTP_OFS_GATE_CTRL)) begin
				gate_en_q <= I_WDATA[`GTP_GATE_EN_BIT]; // [R18]
				gate_pol_q <= I_WDATA[`GTP_GATE_POL_BIT];
				gate_sel_q <= I_WDATA[`GTP_GATE_SEL_LSB+1:`GTP_GATE_SEL_LSB];
			end
		end
	end

	// sticky flags and interrupt enables; a set beats a same-cycle clear
	reg [1:0] flags_q;
	reg [1:0] flags_d;
	reg [1:0] ien_q;
	wire [1:0] flag_set;
	wire [1:0] flag_clr;

	assign flag_set = {c16_tick && (c16_value_q == 16'hFFFF), c8_wrap_d}; // [R7] [R23]
	assign flag_clr = wr_at(`GTP_OFS_STATUS) ?
		{I_WDATA[`GTP_ST_C16_FLAG_BIT], I_WDATA[`GTP_ST_C8_FLAG_BIT]} : 2'h0;

	always @* begin
		flags_d = (flags_q & ~flag_clr) | flag_set; // [R7] [R23]
	end

	always @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			flags_q <= 2'h0;
			ien_q <= 2'h0;
		end else if (I_CE) begin
			flags_q <= flags_d;
			if (wr_at(`GTP_OFS_STATUS)) begin
				ien_q <= {I_WDATA[`GTP_ST_C16_IEN_BIT], I_WDATA[`GTP_ST_C8_IEN_BIT]};
			end
		end
	end

	assign O_COUNT8_IRQ = flags_q[0] & ien_q[0]; // [R7]
	// level usable as a wake request while the core sleeps
	assign O_COUNT16_WAKE_IRQ = flags_q[1] & ien_q[1]; // [R14]

	// secondary oscillator readiness, counted on its own edges
	reg [10:0] osc_cnt_q;
	reg osc_ready_q;
	reg osc_en_prev_q;

	always @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			osc_cnt_q <= 11'h000;
			osc_ready_q <= 1'b0;
			osc_en_prev_q <= 1'b0;
			O_SEC_OSC_OUTPUT_PIN <= 1'b0;
		end else if (I_CE) begin
			osc_en_prev_q <= osc_en;
			// amplifier output keeps toggling in sleep while enabled
			O_SEC_OSC_OUTPUT_PIN <= osc_en & ~sync2_q[3]; // [R11]
			if (!osc_en || !osc_en_prev_q) begin
				osc_cnt_q <= 11'h000; // [R12]
				osc_ready_q <= 1'b0; // [R12]
			end else if (osc_rise_fast && !osc_ready_q) begin
				osc_cnt_q <= osc_cnt_q + 11'h001;
				if (osc_cnt_q + 11'h001 == `GTP_OSC_READY_COUNT) begin
					osc_ready_q <= 1'b1; // [R12]
				end
			end
		end
	end

	assign O_SEC_OSC_READY_FLAG = osc_ready_q;

	// read port: the count is a plain register here, so any byte read is
	// coherent; a carry between the two byte reads is still possible
	reg [7:0] rd_mux;

	always @* begin
		rd_mux = 8'h00;
		case (I_ADDR)
			`GTP_OFS_C8_VALUE: rd_mux = c8_value_q;
			`GTP_OFS_C8_CTRL: rd_mux = {2'h0, c8_ctrl_q};
			`GTP_OFS_C16_LOW: rd_mux = c16_value_q[7:0]; // [R10] [R15]
			`GTP_OFS_C16_HIGH: rd_mux = c16_value_q[15:8]; // [R10] [R15]
			`GTP_OFS_C16_CTRL: rd_mux = {2'h0, c16_ctrl_q};
			`GTP_OFS_GATE_CTRL: rd_mux = {gate_en_q, gate_pol_q, 3'h0, gate_lvl, gate_sel_q};
			`GTP_OFS_STATUS: rd_mux = {2'h0, ien_q, 2'h0, flags_q};
			`GTP_OFS_OSC_STATE: rd_mux = {7'h00, osc_ready_q};
			default: rd_mux = 8'h00;
		endcase
	end

	always @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			O_RDATA <= 8'h00;
		end else if (I_CE) begin
			O_RDATA <= I_RD ? rd_mux : 8'h00;
		end
	end

endmodule

// *** bench/gtp_checker.sv ***
// port checker for gtp_top
// assumes bind into gtp_top, one clock, reset async high
module gtp_checker (
	input wire I_CLOCK,
	input wire I_RST,
	input wire I_CE,
	input wire [3:0] I_ADDR,
	input wire [7:0] I_WDATA,
	input wire I_WR,
	input wire I_RD,
	input wire [7:0] O_RDATA,
	input wire I_SLEEP,
	input wire I_SEC_OSC_INPUT_PIN,
	input wire O_SEC_OSC_OUTPUT_PIN,
	input wire O_COUNT8_WRAP_EVENT,
	input wire O_COUNT8_IRQ,
	input wire O_COUNT16_WAKE_IRQ,
	input wire O_SEC_OSC_READY_FLAG
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] low_q;
	logic [2:0] c8_q;
	wire st_wr = I_CE && I_WR && I_ADDR == 4'h6;
	// cycles since the oscillator was last off: a lower bound for start-up
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			low_q <= 12'h000;
			c8_q <= 3'h0;
		end else begin
			if (O_SEC_OSC_READY_FLAG || (I_CE && I_WR && I_ADDR == 4'h4 && !I_WDATA[3]))
				low_q <= 12'h000;
			else if (I_CE && low_q != 12'hfff)
				low_q <= low_q + 12'h001;
			if (I_CE && I_WR && I_ADDR == 4'h1)
				c8_q <= I_WDATA[2:0];
		end
	end
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);
	property p_idle; $past(I_CE) && !$past(I_RD) |-> O_RDATA == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle");
	property p_unmap; I_CE && I_RD && I_ADDR[3] |=> O_RDATA == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_pulse; O_COUNT8_WRAP_EVENT && I_CE |=> !O_COUNT8_WRAP_EVENT; endproperty
	a_pulse: assert property (p_pulse) else $error("wrap pulse long");
	property p_hold;
		I_CE && I_WR && I_ADDR == 4'h0 && I_WDATA == 8'hff && c8_q[2] && !c8_q[0]
		##1 (I_CE && !I_SLEEP && !I_WR)[*3] |-> !O_COUNT8_WRAP_EVENT ##[1:2] O_COUNT8_WRAP_EVENT;
	endproperty
	a_hold: assert property (p_hold) else $error("write hold");
	property p_irq8; $rose(O_COUNT8_IRQ) |-> O_COUNT8_WRAP_EVENT || $past(st_wr); endproperty
	a_irq8: assert property (p_irq8) else $error("irq8 cause");
	property p_keep8; O_COUNT8_IRQ && !st_wr |=> O_COUNT8_IRQ; endproperty
	a_keep8: assert property (p_keep8) else $error("irq8 lost");
	property p_keep16; O_COUNT16_WAKE_IRQ && !st_wr |=> O_COUNT16_WAKE_IRQ; endproperty
	a_keep16: assert property (p_keep16) else $error("irq16 lost");
	property p_ready; $rose(O_SEC_OSC_READY_FLAG) |-> low_q > 12'h7f8; endproperty
	a_ready: assert property (p_ready) else $error("ready early");
	property p_oscout; (I_CE && O_SEC_OSC_READY_FLAG && !I_SEC_OSC_INPUT_PIN)[*4] |-> O_SEC_OSC_OUTPUT_PIN; endproperty
	a_oscout: assert property (p_oscout) else $error("osc drive");
endmodule

// *** bench/gtp_pins.sv ***
// far side: crystal and count8 clock pin
// assumes the bench sets run and calls pulse8
module gtp_pins (
	output logic o_osc,
	output logic o_ext8
);
	timeunit 1ns;
	timeprecision 1ns;
	bit run = 1'b0;
	initial begin
		o_osc = 1'b0;
		o_ext8 = 1'b0;
	end
	// crystal parks low when stopped, sleep does not stop it
	always begin
		#100;
		o_osc = run & ~o_osc;
	end
	// ends high so rising and falling counts differ by one
	task pulse8(input int n);
		o_ext8 = 1'b0;
		#400;
		repeat (n) begin
			#170 o_ext8 = 1'b1;
			#230 o_ext8 = 1'b0;
		end
		#170 o_ext8 = 1'b1;
	endtask
endmodule

// *** bench/tb.sv ***
// bench for gtp_top
// assumes gtp_pins and gtp_checker in bench
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sleep = 1'b0;
	logic lev = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] got, lo, v;
	wire [7:0] rdata;
	wire osc, ext8, osc_out, irq8, irq16, ready;
	int num_errors = 0;
	int tests_run = 0;
	int n;
	gtp_pins pins (.o_osc(osc), .o_ext8(ext8));
	gtp_top uut (.I_CLOCK(clk), .I_RST(rst), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SLEEP(sleep), .I_COUNT8_EXT_CLOCK_PIN(ext8),
		.I_COUNT16_GATE_PIN(lev), .I_COMPARATOR_A_SYNC_OUT(lev), .I_COMPARATOR_B_SYNC_OUT(lev),
		.I_SEC_OSC_INPUT_PIN(osc), .O_SEC_OSC_OUTPUT_PIN(osc_out), .O_COUNT8_WRAP_EVENT(),
		.O_COUNT8_IRQ(irq8), .O_COUNT16_WAKE_IRQ(irq16), .O_SEC_OSC_READY_FLAG(ready));
	// got holds the answer to the read issued two ops earlier
	task op(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		got = rdata;
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
	endtask
	task nops(input int k);
		repeat (k) op(1'b0, 1'b0, 4'h0, 8'h00);
	endtask
	task rdb(input logic [3:0] a);
		op(1'b0, 1'b1, a, 8'h00);
		nops(2);
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	// counts that cross an async or prescaled start may be one off
	task near(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (!(g === e || g === e + 16'h0001 || g === e - 16'h0001)) begin
			num_errors++;
			$display("CHECK FAILED %0t count %h exp %h", $time, g, e);
		end
	endtask
	task print_verdict;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		forever #25 clk = ~clk;
	end
	initial begin
		#(60000 * 50);
		num_errors++;
		print_verdict;
	end
	initial begin
		void'($urandom(32'hcf3c));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int a = 1; a < 9; a++) begin
			rdb(a[3:0]);
			chk(got, 8'h00);
		end
		op(1'b1, 1'b0, 4'h6, 8'h30);
		op(1'b1, 1'b0, 4'h1, 8'h04);
		for (int k = 0; k < 4; k++) begin
			v = (k == 0) ? 8'hff : 8'($urandom);
			op(1'b1, 1'b0, 4'h0, v);
			for (int i = 0; i < 6; i++) begin
				op(1'b0, i < 4, 4'h0, 8'h00);
				if (i >= 2)
					chk(got, v + {7'h00, i == 5});
			end
		end
		op(1'b1, 1'b0, 4'h0, 8'h00);
		rdb(4'h6);
		chk(got, 8'h31);
		chk({7'h00, irq8}, 8'h01);
		op(1'b1, 1'b0, 4'h6, 8'h31);
		rdb(4'h6);
		chk(got, 8'h30);
		for (int r = 0; r < 8; r++) begin
			op(1'b1, 1'b0, 4'h1, {2'b00, r[2:0], 3'b000});
			op(1'b1, 1'b0, 4'h0, 8'h00);
			nops(40 << (r + 1));
			rdb(4'h0);
			near({8'h00, got}, 16'h0028);
		end
		for (int e = 1; e >= 0; e--) begin
			n = 1 + $urandom % 20;
			op(1'b1, 1'b0, 4'h1, {5'h00, 1'b1, e[0], 1'b1});
			op(1'b1, 1'b0, 4'h0, 8'h00);
			nops(1);
			pins.pulse8(n);
			nops(10);
			rdb(4'h0);
			chk(got, 8'(n + 1 - e));
		end
		op(1'b1, 1'b0, 4'h5, 8'h00);
		for (int p = 0; p < 4; p++) begin
			op(1'b1, 1'b0, 4'h4, 8'h00);
			op(1'b1, 1'b0, 4'h2, 8'hf0);
			op(1'b1, 1'b0, 4'h3, 8'hff);
			op(1'b1, 1'b0, 4'h4, {2'b00, p[1:0], 4'h1});
			nops(64);
			op(1'b1, 1'b0, 4'h4, 8'h00);
			rdb(4'h2);
			lo = got;
			rdb(4'h3);
			near({got, lo}, 16'hfff0 + (16'h0040 >> p));
		end
		rdb(4'h6);
		chk(got & 8'h02, 8'h02);
		chk({7'h00, irq16}, 8'h01);
		for (int g = 0; g < 16; g++) begin
			lev <= g[0];
			op(1'b1, 1'b0, 4'h5, {1'b1, g[1], 4'h0, g[3:2]});
			op(1'b1, 1'b0, 4'h2, 8'h00);
			op(1'b1, 1'b0, 4'h3, 8'h00);
			op(1'b1, 1'b0, 4'h4, 8'h01);
			nops(40);
			op(1'b1, 1'b0, 4'h4, 8'h00);
			rdb(4'h5);
			chk(got, {1'b1, g[1], 3'h0, g[0] & (g[3:2] != 2'h1), g[3:2]});
			rdb(4'h2);
			near({8'h00, got}, (g[0] & (g[3:2] != 2'h1)) == g[1] ? 16'h0028 : 16'h0000);
		end
		// start the oscillator run from a cleared, ungated count
		op(1'b1, 1'b0, 4'h5, 8'h00);
		op(1'b1, 1'b0, 4'h2, 8'h00);
		op(1'b1, 1'b0, 4'h3, 8'h00);
		pins.run = 1'b1;
		op(1'b1, 1'b0, 4'h4, 8'h0f);
		sleep <= 1'b1;
		nops(4000);
		rdb(4'h7);
		chk(got, 8'h00);
		nops(117);
		op(1'b1, 1'b0, 4'h4, 8'h08);
		sleep <= 1'b0;
		rdb(4'h7);
		chk(got, 8'h01);
		rdb(4'h2);
		lo = got;
		rdb(4'h3);
		near({got, lo}, 16'h0406);
		// synchronised external clock: one extra stage, same rate
		op(1'b1, 1'b0, 4'h2, 8'h00);
		op(1'b1, 1'b0, 4'h3, 8'h00);
		op(1'b1, 1'b0, 4'h4, 8'h0b);
		nops(400);
		op(1'b1, 1'b0, 4'h4, 8'h08);
		rdb(4'h2);
		near({8'h00, got}, 16'h0064);
		pins.run = 1'b0;
		nops(10);
		chk({7'h00, osc_out}, 8'h01);
		op(1'b1, 1'b0, 4'h4, 8'h00);
		nops(3);
		chk({7'h00, ready}, 8'h00);
		print_verdict;
	end
endmodule
bind gtp_top gtp_checker u_chk (.*);
